// [logic/_unused_placeholder_never.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [logic/cbsc_ctl.sv]
/*
  Charge short-circuit delay qualification and automatic cell-balance control.
  Assumes comparator and charger inputs arrive asynchronously from the analog
  front end and the register port is driven from logic on clk.
*/
// Behaviour
// - Config: delay code high, threshold low nibble
// - Delay is sixty microseconds times code plus one
// - Threshold 10 to 85 mV, five times higher
// - Gain select bit picks threshold range
// - Balance config: mode, timeout, threshold; 00 off
// - Mode 01: always, timed, rearm below threshold
// - Mode 10: charger only, no timeout
// - Mode 11: charger, timeout, needs charger replug
// - Timer starts when bypass actually starts
// - Timeout 1, 2, 4, 8 hours
// - Charger modes start on charger and cell
// - Start threshold 3.9 V down to 2.4 V
`timescale 1ns/1ps
`default_nettype none

module cbsc_ctl
  import cbsc_pkg::*;
#(
  parameter int SC_STEP_CYC  = cbsc_pkg::CBSC_SC_STEP_CYC,  // Cycles per delay step
  parameter int SEC_CYC      = cbsc_pkg::CBSC_SEC_CYC,      // Cycles per second
  parameter int HOUR_SECONDS = cbsc_pkg::CBSC_HOUR_SECONDS  // Seconds per hour
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Analog front end, asynchronous
  input  wire logic        sense_gain_select,
  input  wire logic        charge_short_comp,
  input  wire logic        cell_at_threshold,
  input  wire logic        charger_present,
  // Thresholds to the comparators
  output logic      [8:0]  charge_short_level_mv,
  output logic      [11:0] balance_start_mv,
  // Status
  output logic             charge_short_circuit,
  output logic             balance_active,
  output logic             balance_expired
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Magnitude of the negative trip level in mV
  function automatic logic [8:0] sc_level(input logic [3:0] code, input logic gain);
    logic [8:0] lvl;
    lvl = CBSC_SC_BASE_MV + 9'(code) * CBSC_SC_STEP_MV;
    return gain ? 9'(lvl * 9'h005) : lvl;
  endfunction

  // Start threshold in mV
  function automatic logic [11:0] bal_level(input logic [3:0] code);
    return CBSC_BAL_TOP_MV - 12'(code) * CBSC_BAL_STEP_MV;
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] charge_short_config_q; // Delay and threshold codes
  logic [7:0] balance_config_q;      // Mode, timeout and threshold
  logic [7:0] reg_rdata_q;           // Registered read answer

  // Writes at the two documented addresses; others are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_short_config_q <= CBSC_CHARGE_SHORT_RST;
      balance_config_q      <= CBSC_BALANCE_RST;
    end else if (reg_wr) begin
      if (reg_addr == CBSC_ADDR_CHARGE_SHORT) begin
        charge_short_config_q <= reg_wdata;
      end else if (reg_addr == CBSC_ADDR_BALANCE) begin
        balance_config_q <= reg_wdata;
      end
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= CBSC_UNMAPPED_READ;
    end else if (reg_rd) begin
      if (reg_addr == CBSC_ADDR_CHARGE_SHORT) begin
        reg_rdata_q <= charge_short_config_q;
      end else if (reg_addr == CBSC_ADDR_BALANCE) begin
        reg_rdata_q <= balance_config_q;
      end else begin
        reg_rdata_q <= CBSC_UNMAPPED_READ;
      end
    end
  end
  assign reg_rdata = reg_rdata_q;

  // Field extraction
  logic [3:0] charge_short_delay_code;
  logic [3:0] charge_short_threshold_code;
  logic [1:0] balance_enable_mode;
  logic [1:0] balance_timeout_code;
  logic [3:0] balance_start_threshold_code;
  assign charge_short_delay_code      = charge_short_config_q[CBSC_SC_DELAY_LSB +: 4];
  assign charge_short_threshold_code  = charge_short_config_q[CBSC_SC_THRESH_LSB +: 4];
  assign balance_enable_mode          = balance_config_q[CBSC_BAL_MODE_LSB +: 2];
  assign balance_timeout_code         = balance_config_q[CBSC_BAL_TMO_LSB +: 2];
  assign balance_start_threshold_code = balance_config_q[CBSC_BAL_THRESH_LSB +: 4];

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q; // First stage, read only by the second
  logic [3:0] sync2_q; // Safe copies
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {sense_gain_select, charge_short_comp, cell_at_threshold, charger_present};
      sync2_q <= sync1_q;
    end
  end
  logic gain_s, comp_s, cell_s, chg_s;
  assign {gain_s, comp_s, cell_s, chg_s} = sync2_q;

  // ----------------------------------------------------------------------
  // Comparator thresholds
  // ----------------------------------------------------------------------
  logic [8:0]  sc_level_q;  // Trip magnitude in mV
  logic [11:0] bal_level_q; // Start level in mV
  // Gain select scales the trip range by five
  always_ff @(posedge clk) begin
    if (rst) begin
      sc_level_q  <= 9'h000;
      bal_level_q <= 12'h000;
    end else begin
      sc_level_q  <= sc_level(charge_short_threshold_code, gain_s);
      bal_level_q <= bal_level(balance_start_threshold_code);
    end
  end
  assign charge_short_level_mv = sc_level_q;
  assign balance_start_mv      = bal_level_q;

  // ----------------------------------------------------------------------
  // Charge short-circuit delay
  // ----------------------------------------------------------------------
  // Counting cycles directly avoids a prescaler phase error on short delays
  logic [17:0] sc_cnt_q;   // Cycles with comparator held
  logic [17:0] sc_target;  // Cycles for the selected delay
  logic        sc_fault_q; // Qualified fault
  assign sc_target = 18'((32'(charge_short_delay_code) + 32'd1) * 32'(SC_STEP_CYC));

  always_ff @(posedge clk) begin
    if (rst) begin
      sc_cnt_q   <= 18'h00000;
      sc_fault_q <= 1'b0;
    end else if (!comp_s) begin
      sc_cnt_q   <= 18'h00000;
      sc_fault_q <= 1'b0;
    end else if (sc_cnt_q >= sc_target - 18'h00001) begin
      sc_fault_q <= 1'b1;
    end else begin
      sc_cnt_q <= sc_cnt_q + 18'h00001;
    end
  end
  assign charge_short_circuit = sc_fault_q;

  // ----------------------------------------------------------------------
  // Balance timer prescaler
  // ----------------------------------------------------------------------
  logic sec_tick; // One pulse per second
  cbsc_divider #(
    .DIV (SEC_CYC)
  ) u_sec_div (
    .clk  (clk),
    .rst  (rst),
    .en   (1'b1),
    .tick (sec_tick)
  );

  // ----------------------------------------------------------------------
  // Balance controller
  // ----------------------------------------------------------------------
  cbsc_state_t state_q;    // Controller state
  logic [31:0] bal_sec_q;  // Seconds balanced so far
  logic [31:0] tmo_sec;    // Selected timeout in seconds
  logic        expiry;     // Timeout reached this cycle
  cbsc_mode_t  mode;       // Decoded enable mode
  assign mode    = cbsc_mode_t'(balance_enable_mode);
  assign tmo_sec = 32'(HOUR_SECONDS) << balance_timeout_code;
  assign expiry  = (bal_sec_q >= tmo_sec) && (mode != CBSC_MODE_CHARGER);

  // Timer runs only while current is actually bypassed
  always_ff @(posedge clk) begin
    if (rst) begin
      bal_sec_q <= 32'h0000_0000;
    end else if (state_q != CBSC_ST_BALANCE) begin
      bal_sec_q <= 32'h0000_0000;
    end else if (sec_tick && (bal_sec_q < tmo_sec)) begin
      bal_sec_q <= bal_sec_q + 32'h0000_0001;
    end
  end

  // Mode-dependent start, stop and rearm
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CBSC_ST_IDLE;
    end else if (mode == CBSC_MODE_OFF) begin
      state_q <= CBSC_ST_IDLE;
    end else begin
      case (state_q)
        CBSC_ST_IDLE: begin
          // Always mode ignores the charger
          if (cell_s && (mode == CBSC_MODE_ALWAYS || chg_s)) begin
            state_q <= CBSC_ST_BALANCE;
          end
        end
        CBSC_ST_BALANCE: begin
          if (mode != CBSC_MODE_ALWAYS && !chg_s) begin
            state_q <= CBSC_ST_IDLE;
          end else if (expiry) begin
            state_q <= CBSC_ST_REARM;
          end
        end
        CBSC_ST_REARM: begin
          // Always mode rearms when cells drop; charger modes on unplug
          if (mode == CBSC_MODE_ALWAYS ? !cell_s : !chg_s) begin
            state_q <= CBSC_ST_IDLE;
          end
        end
        default: begin
          state_q <= CBSC_ST_IDLE;
        end
      endcase
    end
  end
  assign balance_active  = (state_q == CBSC_ST_BALANCE);
  assign balance_expired = (state_q == CBSC_ST_REARM);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_sc_no_early: assert property (@(posedge clk) disable iff (rst)
    $rose(sc_fault_q) |-> $past(comp_s) && (sc_cnt_q == sc_target - 18'h00001))
    else $error("short fault raised before full delay");

  a_sc_clear_drop: assert property (@(posedge clk) disable iff (rst)
    !comp_s |=> !sc_fault_q && (sc_cnt_q == 18'h00000))
    else $error("short fault held after comparator dropped");

  // Fault rises only once the held count matches one less than step times code plus one
  a_sc_delay_math: assert property (@(posedge clk) disable iff (rst)
    $rose(sc_fault_q) |->
      sc_cnt_q == 18'(SC_STEP_CYC * (int'(charge_short_delay_code) + 1) - 1))
    else $error("short delay count wrong");

  // Level register lags its inputs by one edge, so compare with their past
  a_sc_level_gain: assert property (@(posedge clk) disable iff (rst)
    $stable(charge_short_threshold_code) && $stable(gain_s) |=>
      sc_level_q == 9'((10 + 5 * int'($past(charge_short_threshold_code)))
                       * ($past(gain_s) ? 5 : 1)))
    else $error("short trip level wrong");

  a_bal_level_map: assert property (@(posedge clk) disable iff (rst)
    $stable(balance_start_threshold_code) |=>
      bal_level_q == 12'(3900 - 100 * int'($past(balance_start_threshold_code))))
    else $error("balance start level wrong");

  a_bal_off_mode: assert property (@(posedge clk) disable iff (rst)
    mode == CBSC_MODE_OFF |=> !balance_active && !balance_expired)
    else $error("balancing while disabled");

  a_bal_chg_loss: assert property (@(posedge clk) disable iff (rst)
    balance_active && !chg_s && mode != CBSC_MODE_ALWAYS && mode != CBSC_MODE_OFF
      |=> state_q == CBSC_ST_IDLE)
    else $error("balancing kept after charger removal");

  a_bal_no_tmo10: assert property (@(posedge clk) disable iff (rst)
    balance_active && mode == CBSC_MODE_CHARGER && chg_s |=> !balance_expired)
    else $error("timeout in charger-only mode");

  a_bal_timer_start: assert property (@(posedge clk) disable iff (rst)
    $rose(balance_active) |-> bal_sec_q == 32'h0000_0000)
    else $error("balance timer not fresh at start");

  a_bal_rearm_hold: assert property (@(posedge clk) disable iff (rst)
    balance_expired && mode == CBSC_MODE_ALWAYS && cell_s |=> !balance_active)
    else $error("restart without cells falling below");

endmodule // cbsc_ctl

`default_nettype wire

// [logic/cbsc_divider.sv]
/*
  Enable-driven divider: emits a one-cycle tick every DIV enabled cycles.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cbsc_divider #(
  parameter int DIV = 40_000_000 // Enabled cycles per tick
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Count enable and tick
  input  wire logic en,
  output logic      tick
);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [31:0] cnt_q; // Wide enough for any sensible divide

  // Count enabled cycles, wrap at the last one
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
    end else if (en) begin
      if (cnt_q == 32'(DIV - 1)) begin
        cnt_q <= 32'h0000_0000;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

  // Tick on the wrapping cycle only
  assign tick = en && (cnt_q == 32'(DIV - 1));

endmodule // cbsc_divider

`default_nettype wire

// [logic/cbsc_pkg.sv]
/*
  Constants shared by the charge short-circuit and cell-balance control block:
  register offsets, field positions, reset values, timing figures and modes.
  Assumes a 40 MHz device clock.
*/
package cbsc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CBSC_ADDR_CHARGE_SHORT = 8'h09; // charge_short_config
  localparam logic [7:0] CBSC_ADDR_BALANCE      = 8'h0A; // balance_config
  localparam logic [7:0] CBSC_CHARGE_SHORT_RST  = 8'h00; // Value after reset
  localparam logic [7:0] CBSC_BALANCE_RST       = 8'h00; // Value after reset
  localparam logic [7:0] CBSC_UNMAPPED_READ     = 8'h00; // Answer off the map

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CBSC_SC_DELAY_LSB   = 4; // Delay code, bits 7:4
  localparam int CBSC_SC_THRESH_LSB  = 0; // Threshold code, bits 3:0
  localparam int CBSC_BAL_MODE_LSB   = 6; // Enable mode, bits 7:6
  localparam int CBSC_BAL_TMO_LSB    = 4; // Timeout code, bits 5:4
  localparam int CBSC_BAL_THRESH_LSB = 0; // Start threshold, bits 3:0

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CBSC_CLK_HZ       = 40_000_000; // Device clock rate
  localparam int CBSC_SC_STEP_US   = 60;         // Delay step in microseconds
  localparam int CBSC_SC_STEP_CYC  = CBSC_SC_STEP_US * (CBSC_CLK_HZ / 1_000_000);
  localparam int CBSC_SEC_CYC      = CBSC_CLK_HZ; // Cycles per second
  localparam int CBSC_HOUR_SECONDS = 3600;        // Seconds per hour

  // ----------------------------------------------------------------------
  // Threshold scales
  // ----------------------------------------------------------------------
  localparam logic [8:0]  CBSC_SC_BASE_MV  = 9'h00A;  // 10 mV magnitude at code 0
  localparam logic [8:0]  CBSC_SC_STEP_MV  = 9'h005;  // 5 mV per code step
  localparam logic [11:0] CBSC_BAL_TOP_MV  = 12'hF3C; // 3900 mV at code 0
  localparam logic [11:0] CBSC_BAL_STEP_MV = 12'h064; // 100 mV per code step

  // ----------------------------------------------------------------------
  // Balance enable modes and controller states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CBSC_MODE_OFF     = 2'h0,
    CBSC_MODE_ALWAYS  = 2'h1,
    CBSC_MODE_CHARGER = 2'h2,
    CBSC_MODE_CHG_TMO = 2'h3
  } cbsc_mode_t;

  typedef enum logic [1:0] {
    CBSC_ST_IDLE,
    CBSC_ST_BALANCE,
    CBSC_ST_REARM
  } cbsc_state_t;

endpackage : cbsc_pkg

// [testbench/cbsc_afe_model.sv]
/*
  Behavioural analog front end: charge short comparator, cell comparator and
  charger detection, all ideal and without hysteresis.
  Assumes the bench changes the millivolt figures between clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module cbsc_afe_model (
  // Analog figures set by the bench
  input  wire logic [15:0] sense_mv,
  input  wire logic [15:0] cell_mv,
  input  wire logic        charger_on,
  // Levels published by the controller
  input  wire logic [8:0]  charge_short_level_mv,
  input  wire logic [11:0] balance_start_mv,
  // Comparator results
  output logic             charge_short_comp,
  output logic             cell_at_threshold,
  output logic             charger_present
);
  // ----------------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------------
  // Strict compare: a sense figure equal to the level does not trip, so a
  // zero level during reset cannot fake a short
  assign charge_short_comp = (sense_mv > {7'h00, charge_short_level_mv});
  // Cell trips once it reaches the start level
  assign cell_at_threshold = (cell_mv >= {4'h0, balance_start_mv});
  // Charger detect follows the bench directly
  assign charger_present   = charger_on;
endmodule // cbsc_afe_model

`default_nettype wire

// [testbench/cbsc_ctl_tb.sv]
/*
  Self-checking bench for the charge short and cell-balance controller.
  Assumes cbsc_pkg and cbsc_afe_model are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("[FAIL] %s expected %0d seen %0d", nm, ex, got); \
  end \
end

module cbsc_ctl_tb;
  import cbsc_pkg::*;
  // ----------------------------------------------------------------------
  // Shortened counts, so hours become cycles
  // ----------------------------------------------------------------------
  localparam int STEP  = 4;    // Cycles per delay step
  localparam int SEC   = 5;    // Cycles per second
  localparam int HOUR  = 3;    // Seconds per hour
  localparam int LIMIT = 6000; // Ceiling on the whole run

  logic        clk;                   // Device clock
  logic        rst;                   // Synchronous reset
  logic [7:0]  reg_addr;              // Register port
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        sense_gain_select;     // Gain bit pin
  logic        charge_short_comp;     // Front end results
  logic        cell_at_threshold;
  logic        charger_present;
  logic [8:0]  charge_short_level_mv; // Published levels
  logic [11:0] balance_start_mv;
  logic        charge_short_circuit;  // Status
  logic        balance_active;
  logic        balance_expired;
  logic [15:0] sense_mv;              // Analog figures
  logic [15:0] cell_mv;
  logic        charger_on;
  int          seed = 37600;          // Fixed seed
  int          err_total = 0;         // Mismatches
  int          samples_checked = 0;   // Comparisons
  int          cycles = 0;            // Hang guard
  int          k, t, h, thr, lo;
  int          dly_codes[$] = '{0, 5, 15}; // Shortest, middle, longest delay

  cbsc_ctl #(.SC_STEP_CYC(STEP), .SEC_CYC(SEC), .HOUR_SECONDS(HOUR)) u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sense_gain_select(sense_gain_select), .charge_short_comp(charge_short_comp),
    .cell_at_threshold(cell_at_threshold), .charger_present(charger_present),
    .charge_short_level_mv(charge_short_level_mv), .balance_start_mv(balance_start_mv),
    .charge_short_circuit(charge_short_circuit), .balance_active(balance_active),
    .balance_expired(balance_expired));

  cbsc_afe_model u_afe (
    .sense_mv(sense_mv), .cell_mv(cell_mv), .charger_on(charger_on),
    .charge_short_level_mv(charge_short_level_mv), .balance_start_mv(balance_start_mv),
    .charge_short_comp(charge_short_comp), .cell_at_threshold(cell_at_threshold),
    .charger_present(charger_present));

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin // Run hung somewhere
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks and helpers; all driving happens on the falling edge
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input int ex);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask
  // Waits, bounded, until fault (sel 0) or balancing (sel 1) shows val
  task automatic wait_for(input int sel, input logic val, input int max, output int n);
    n = 0;
    while ((sel == 0 ? charge_short_circuit : balance_active) !== val && n < max) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Bounded timeout wait and duration window; first second may run short
  task automatic expiry(input int hrs);
    wait_for(1, 1'b0, hrs * HOUR * SEC + 6, k);
    `CHK("balance run", 1, int'(k >= (hrs * HOUR - 1) * SEC && k <= hrs * HOUR * SEC + 2))
    `CHK("balance_expired", 1, balance_expired)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, reg_addr, reg_wr, reg_wdata, reg_rd, sense_gain_select} = '0;
    {sense_mv, cell_mv, charger_on} = '0;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    // Reset values and an unmapped read
    rd_chk(CBSC_ADDR_CHARGE_SHORT, 0);
    rd_chk(CBSC_ADDR_BALANCE, 0);
    rd_chk(8'h0B, 0);
    // Random fields; stray write off the map must not land
    for (int i = 0; i < 4; i++) begin
      h = $random(seed);
      t = $random(seed);
      wr(CBSC_ADDR_CHARGE_SHORT, h[7:0]);
      wr(CBSC_ADDR_BALANCE, {2'b00, t[5:0]});
      wr(8'h08, 8'hFF);
      rd_chk(CBSC_ADDR_CHARGE_SHORT, h[7:0]);
      rd_chk(CBSC_ADDR_BALANCE, {2'b00, t[5:0]});
    end
    // Read in the same cycle as a write sees the old value
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {CBSC_ADDR_CHARGE_SHORT, 8'h5A, 2'b11};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
    `CHK("rdata old", h[7:0], reg_rdata)
    rd_chk(CBSC_ADDR_CHARGE_SHORT, 8'h5A);
    // Every threshold code in both gain ranges, delay nibble random
    for (int g = 0; g < 2; g++) begin
      sense_gain_select = g[0];
      for (int c = 0; c < 16; c++) begin
        h = $random(seed);
        wr(CBSC_ADDR_CHARGE_SHORT, {h[3:0], c[3:0]});
        wr(CBSC_ADDR_BALANCE, {2'b00, h[5:4], c[3:0]});
        tick(4);
        `CHK("short level", (10 + 5 * c) * (g ? 5 : 1), charge_short_level_mv)
        `CHK("gain range", g ? 5 : 1, charge_short_level_mv / (10 + 5 * c))
        `CHK("balance level", 3900 - 100 * c, balance_start_mv)
      end
    end
    // Short delay: a one-cycle drop just before the count completes restarts it
    sense_gain_select = 1'b0;
    foreach (dly_codes[i]) begin
      t = (dly_codes[i] + 1) * STEP;
      wr(CBSC_ADDR_CHARGE_SHORT, {dly_codes[i][3:0], 4'h2});
      tick(4);
      sense_mv = 16'd21 + 16'($unsigned($random(seed)) % 40);
      tick(t - 1);
      `CHK("short early", 0, charge_short_circuit)
      sense_mv = 16'd20;
      tick(1);
      sense_mv = 16'd45;
      wait_for(0, 1'b1, t + 8, k);
      `CHK("short delay", 1, int'(k >= t + 1 && k <= t + 4))
      sense_mv = 16'd20;
      wait_for(0, 1'b0, 6, k);
      `CHK("short clear", 0, charge_short_circuit)
    end
    sense_mv = 16'd0;
    thr = $unsigned($random(seed)) % 16;
    lo = 3900 - 100 * thr - 100;
    // Mode 00: nothing happens whatever the inputs
    wr(CBSC_ADDR_BALANCE, {4'h0, thr[3:0]});
    {cell_mv, charger_on} = {16'(lo + 150), 1'b1};
    tick(20);
    `CHK("mode 00", 0, balance_active)
    charger_on = 1'b0;
    // Mode 01: every timeout code, no rearm until cells fall back
    for (int tc = 0; tc < 4; tc++) begin
      cell_mv = 16'(lo);
      wr(CBSC_ADDR_BALANCE, {2'b01, tc[1:0], thr[3:0]});
      tick(4);
      cell_mv = 16'(lo + 100);
      wait_for(1, 1'b1, 6, k);
      `CHK("mode 01 start", 1, balance_active)
      expiry(1 << tc);
      tick(10);
      `CHK("mode 01 hold off", 0, balance_active)
      cell_mv = 16'(lo);
      tick(5);
      cell_mv = 16'(lo + 100);
      wait_for(1, 1'b1, 6, k);
      `CHK("mode 01 rearm", 1, balance_active)
      wr(CBSC_ADDR_BALANCE, 8'h00);
    end
    // Mode 10: charger and cell both needed, no timeout
    cell_mv = 16'(lo);
    charger_on = 1'b1;
    wr(CBSC_ADDR_BALANCE, {4'h8, thr[3:0]});
    tick(10);
    `CHK("mode 10 cell low", 0, balance_active)
    charger_on = 1'b0;
    cell_mv = 16'(lo + 100);
    tick(10);
    `CHK("mode 10 no charger", 0, balance_active)
    charger_on = 1'b1;
    wait_for(1, 1'b1, 6, k);
    `CHK("mode 10 start", 1, balance_active)
    tick(8 * HOUR * SEC + 20);
    `CHK("mode 10 untimed", 1, balance_active)
    charger_on = 1'b0;
    wait_for(1, 1'b0, 6, k);
    `CHK("mode 10 removal", 0, balance_active)
    // Mode 11: timer runs from balancing, not from charger detection
    cell_mv = 16'(lo);
    charger_on = 1'b1;
    wr(CBSC_ADDR_BALANCE, {4'hD, thr[3:0]});
    tick(40);
    cell_mv = 16'(lo + 100);
    wait_for(1, 1'b1, 6, k);
    `CHK("mode 11 start", 1, balance_active)
    expiry(2);
    tick(10);
    `CHK("mode 11 locked", 0, balance_active)
    charger_on = 1'b0;
    tick(5);
    charger_on = 1'b1;
    wait_for(1, 1'b1, 6, k);
    `CHK("mode 11 replug", 1, balance_active)
    charger_on = 1'b0;
    wait_for(1, 1'b0, 6, k);
    `CHK("mode 11 removal", 0, balance_active)
    summarize();
  end
endmodule // cbsc_ctl_tb

`default_nettype wire
